// ---- design/ppc_regs.svh ----
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// register offsets
`define PPC_PULLUP_OFS 4'h0
`define PPC_SLEW_OFS 4'h1
`define PPC_DRIVE_OFS 4'h2
`define PPC_OPTIONS_OFS 4'h3
`define PPC_STATUS_OFS 4'h4

// field positions in system_options_one
`define PPC_OPT_DBG_BIT 0
`define PPC_OPT_RST_BIT 1

// field positions in the status register
`define PPC_STA_DBG_BIT 0
`define PPC_STA_BG_BIT 1
`define PPC_STA_RST_BIT 2

// reset values
`define PPC_PULLUP_RST 6'h00
`define PPC_SLEW_RST 6'h10
`define PPC_DRIVE_RST 6'h00

// pin numbers with special roles
`define PPC_DBG_PIN 4
`define PPC_RST_PIN 5

// debug wire bit time in debug clock cycles
`define PPC_DBG_BIT_CYCLES 16

`endif

// ---- design/ppc_pkg.sv ----
package ppc_pkg;

    typedef enum logic [1:0] {
        PPC_P5_GPIO,
        PPC_P5_TIMER,
        PPC_P5_IRQ,
        PPC_P5_RESET
    } ppc_p5_role_t;

    typedef struct packed {
        logic [5:0] pe;
        logic [5:0] se;
        logic [5:0] ds;
        logic dbg_en;
        logic rst_en;
        logic bg;
        logic kind_por;
        logic kind_dbg;
        logic rst_d;
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] pin_in;
        logic [5:0] oe;
        logic [5:0] dout;
        logic [5:0] pu;
        logic [5:0] pd;
        logic [5:0] sl;
        logic [5:0] hd;
        logic [3:0] ana_a;
        logic [3:0] ana_b;
        logic dbg_rx;
        logic irq_in;
        logic rst_pin_b;
        ppc_p5_role_t p5_role;
        logic [7:0] rdata;
    } ppc_state_t;

endpackage

// ---- design/ppc_pin_ctrl.sv ----
`timescale 1ns/1ns
`include "ppc_regs.svh"
// Summary of operation
// - during power-on or debug force reset the debug pin is a mode-select input
// - after any reset the debug pin takes its debug communication role
// - debug pin enable set turns the debug pin pullup on
// - every reset sets debug pin enable; software clears it for other uses
// - mode pin high at power-on or debug force reset release gives run mode, low gives background mode
// - a debug bit time lasts 16 debug clock cycles
// - the debug wire is pseudo open-drain with short driven-high speedup pulses
// - output pins get selectable drive strength and slew limiting
// - after reset non-output-only pins are inputs with pullups off, except pin five in its reset role
// - after reset output-only pin is off, low drive, slew limited
// - pad control bits are independent of port data and direction
// - pullup only when enabled and pin not driven as output, except debug pin with debug enable set and pin five as reset
// - analog control forces the pullup off
// - rising-edge keypad or irq detection turns the pullup into a pulldown
// - slew limiting is per pin and ignored while the pin is an input
// - drive bit set selects high drive, clear selects low drive
// - each shared pin goes to its highest-priority enabled function
// - both analog modules sharing a pin both get connected
// - reset pin enable makes pin five the reset input until power-on reset
module ppc_pin_ctrl (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_por,
    input wire logic i_force_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [5:0] i_pad_di,
    input wire logic [5:0] i_port_dir,
    input wire logic [5:0] i_port_do,
    input wire logic [3:0] i_kbi_en,
    input wire logic [3:0] i_kbi_rise,
    input wire logic [1:0] i_tpm1_oe,
    input wire logic [1:0] i_tpm1_do,
    input wire logic [1:0] i_tclk_en,
    input wire logic [3:0] i_ana_a_en,
    input wire logic [3:0] i_ana_b_en,
    input wire logic i_tpm2_oe,
    input wire logic i_tpm2_do,
    input wire logic i_tpm2_ic_en,
    input wire logic i_irq_en,
    input wire logic i_irq_rise,
    input wire logic i_bdc_oe,
    input wire logic i_bdc_do,
    output logic [7:0] o_rdata,
    output logic [5:0] o_pad_oe,
    output logic [5:0] o_pad_do,
    output logic [5:0] o_pad_pu,
    output logic [5:0] o_pad_pd,
    output logic [5:0] o_pad_slew,
    output logic [5:0] o_pad_hd,
    output logic [5:0] o_pin_in,
    output logic [3:0] o_ana_a_conn,
    output logic [3:0] o_ana_b_conn,
    output logic o_dbg_rx,
    output logic o_dbg_role,
    output logic o_mode_bg,
    output logic o_irq_in,
    output logic o_rst_pin_b,
    output ppc_pkg::ppc_p5_role_t o_p5_role
);
    import ppc_pkg::*;

    ppc_state_t s;
    ppc_state_t n;

    logic act;
    logic an;
    logic kb;
    logic rise;
    logic pull;
    logic [3:0] tmr_oe;
    logic [3:0] tmr_do;
    logic [3:0] tmr_in;

    always_comb begin
        n = s;
        act = i_rst_b;
        an = 1'b0;
        kb = 1'b0;
        rise = 1'b0;
        pull = 1'b0;
        tmr_oe = {2'b00, i_tpm1_oe};
        tmr_do = {2'b00, i_tpm1_do};
        tmr_in = {i_tclk_en, 2'b00};
        // pins are foreign to the bus clock, so two stages before use
        n.s1 = i_pad_di;
        n.s2 = s.s1;
        n.pin_in = s.s2;
        n.rst_d = i_rst_b;
        n.rdata = 8'h00;
        if (!i_rst_b) begin
            n.pe = `PPC_PULLUP_RST;
            n.se = `PPC_SLEW_RST;
            n.ds = `PPC_DRIVE_RST;
            n.dbg_en = 1'b1;
            n.kind_por = s.kind_por | i_por;
            n.kind_dbg = s.kind_dbg | i_force_rst;
            if (i_por) begin
                n.rst_en = 1'b0;
                n.bg = 1'b0;
            end
        end else begin
            // release edge: latch the mode pin only after the reset kinds that sample it
            if (!s.rst_d && (s.kind_por || s.kind_dbg)) begin
                n.bg = ~s.s2[`PPC_DBG_PIN];
                // a power-on into background mode hands pin five to reset
                if (s.kind_por && !s.s2[`PPC_DBG_PIN]) begin
                    n.rst_en = 1'b1;
                end
                n.kind_por = 1'b0;
                n.kind_dbg = 1'b0;
            end
            if (i_wr) begin
                case (i_addr)
                    `PPC_PULLUP_OFS: n.pe = i_wdata[5:0];
                    `PPC_SLEW_OFS: n.se = i_wdata[5:0];
                    `PPC_DRIVE_OFS: n.ds = i_wdata[5:0];
                    `PPC_OPTIONS_OFS: begin
                        n.dbg_en = i_wdata[`PPC_OPT_DBG_BIT];
                        // write-once: only power-on reset gives the pin back
                        if (i_wdata[`PPC_OPT_RST_BIT]) begin
                            n.rst_en = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (i_rd) begin
                case (i_addr)
                    `PPC_PULLUP_OFS: n.rdata = {2'b00, s.pe};
                    `PPC_SLEW_OFS: n.rdata = {2'b00, s.se};
                    `PPC_DRIVE_OFS: n.rdata = {2'b00, s.ds};
                    `PPC_OPTIONS_OFS: n.rdata = {6'h00, s.rst_en, s.dbg_en};
                    `PPC_STATUS_OFS: n.rdata = {5'h00, s.rst_en, s.bg, s.dbg_en};
                    default: n.rdata = 8'h00;
                endcase
            end
        end

        // pins 0..3: analog > timer > keypad > port
        for (int i = 0; i < 4; i++) begin
            an = act & (i_ana_a_en[i] | i_ana_b_en[i]);
            kb = act & i_kbi_en[i];
            n.oe[i] = ~an & act & (tmr_oe[i] | (~tmr_in[i] & ~kb & i_port_dir[i]));
            n.dout[i] = tmr_oe[i] ? tmr_do[i] : i_port_do[i];
            rise = kb & i_kbi_rise[i];
            pull = n.pe[i] & ~n.oe[i] & ~an;
            n.pu[i] = pull & ~rise;
            n.pd[i] = pull & rise;
        end
        n.ana_a = act ? i_ana_a_en : 4'h0;
        n.ana_b = act ? i_ana_b_en : 4'h0;

        // pin 4: debug > timer output > output-only port
        if (!act) begin
            n.oe[`PPC_DBG_PIN] = 1'b0;
            n.dout[`PPC_DBG_PIN] = 1'b0;
        end else if (n.dbg_en) begin
            // the controller drives low and brief high speedup pulses itself
            n.oe[`PPC_DBG_PIN] = i_bdc_oe;
            n.dout[`PPC_DBG_PIN] = i_bdc_do;
        end else if (i_tpm2_oe) begin
            n.oe[`PPC_DBG_PIN] = 1'b1;
            n.dout[`PPC_DBG_PIN] = i_tpm2_do;
        end else begin
            n.oe[`PPC_DBG_PIN] = i_port_dir[`PPC_DBG_PIN];
            n.dout[`PPC_DBG_PIN] = i_port_do[`PPC_DBG_PIN];
        end
        n.pu[`PPC_DBG_PIN] = n.dbg_en | (n.pe[`PPC_DBG_PIN] & ~n.oe[`PPC_DBG_PIN]);
        n.pd[`PPC_DBG_PIN] = 1'b0;
        n.dbg_rx = n.dbg_en & s.s2[`PPC_DBG_PIN];

        // pin 5 is input only: reset > irq > timer capture > port
        n.oe[`PPC_RST_PIN] = 1'b0;
        n.dout[`PPC_RST_PIN] = 1'b0;
        if (n.rst_en) begin
            n.p5_role = PPC_P5_RESET;
        end else if (act && i_irq_en) begin
            n.p5_role = PPC_P5_IRQ;
        end else if (act && i_tpm2_ic_en) begin
            n.p5_role = PPC_P5_TIMER;
        end else begin
            n.p5_role = PPC_P5_GPIO;
        end
        rise = (n.p5_role == PPC_P5_IRQ) & i_irq_rise;
        n.pu[`PPC_RST_PIN] = (n.p5_role == PPC_P5_RESET) | (n.pe[`PPC_RST_PIN] & ~rise);
        n.pd[`PPC_RST_PIN] = (n.p5_role != PPC_P5_RESET) & n.pe[`PPC_RST_PIN] & rise;
        n.irq_in = (n.p5_role == PPC_P5_IRQ) & s.s2[`PPC_RST_PIN];
        n.rst_pin_b = (n.p5_role != PPC_P5_RESET) | s.s2[`PPC_RST_PIN];

        // pad settings only reach a pin that is actually driving
        n.sl = n.se & n.oe;
        n.hd = n.ds & n.oe;
    end

    always_ff @(posedge i_clk_sys) begin
        s <= n;
    end

    assign o_rdata = s.rdata;
    assign o_pad_oe = s.oe;
    assign o_pad_do = s.dout;
    assign o_pad_pu = s.pu;
    assign o_pad_pd = s.pd;
    assign o_pad_slew = s.sl;
    assign o_pad_hd = s.hd;
    assign o_pin_in = s.pin_in;
    assign o_ana_a_conn = s.ana_a;
    assign o_ana_b_conn = s.ana_b;
    assign o_dbg_rx = s.dbg_rx;
    assign o_dbg_role = s.dbg_en;
    assign o_mode_bg = s.bg;
    assign o_irq_in = s.irq_in;
    assign o_rst_pin_b = s.rst_pin_b;
    assign o_p5_role = s.p5_role;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    a_mode_input_reset: assert property (disable iff (1'b0) !i_rst_b |=> !o_pad_oe[4])
        else $error("debug pin driven during reset");
    a_dbg_after_reset: assert property ($rose(i_rst_b) |-> o_dbg_role && o_pad_pu[4])
        else $error("debug role missing after reset");
    a_dbg_pullup_on: assert property (o_dbg_role |-> o_pad_pu[4])
        else $error("debug pin pullup off while enabled");
    a_mode_sample_val: assert property ((!s.rst_d && (s.kind_por || s.kind_dbg)) |=>
        o_mode_bg == !$past(s.s2[4]))
        else $error("mode not taken from pin at release");
    a_out_no_pull: assert property (((o_pad_oe & (o_pad_pu | o_pad_pd)) & 6'h2f) == 6'h00)
        else $error("pull device on a driven pin");
    a_analog_pull_off: assert property ((i_ana_a_en[1] || i_ana_b_en[1]) |=>
        !o_pad_pu[1] && !o_pad_pd[1] && !o_pad_oe[1])
        else $error("pull on analog pin");
    a_irq_rise_pd: assert property ((i_irq_en && i_irq_rise && !s.rst_en && s.pe[5] && !i_wr) |=>
        o_pad_pd[5] && !o_pad_pu[5])
        else $error("rising irq pull not pulldown");
    a_slew_input_off: assert property ((o_pad_slew & ~o_pad_oe) == 6'h00)
        else $error("slew on an input");
    a_drive_follows: assert property ((i_wr && i_addr == `PPC_DRIVE_OFS) ##1 o_pad_oe[0] |->
        o_pad_hd[0] == $past(i_wdata[0]))
        else $error("drive strength not from bit");
    a_rst_role_kept: assert property ((s.rst_en && !i_por) |=> s.rst_en && o_p5_role == PPC_P5_RESET)
        else $error("reset pin role lost");
    a_read_latency: assert property ((i_rd && i_addr == `PPC_PULLUP_OFS && !i_wr) |=>
        o_rdata == {2'b00, $past(s.pe)})
        else $error("pullup read back wrong");
    // pad defaults must already stand while reset is still held
    a_reset_pads: assert property (disable iff (1'b0) !i_rst_b |=>
        o_dbg_role && o_pad_slew == 6'h00 && o_pad_hd == 6'h00 && o_pad_pd == 6'h00)
        else $error("pad defaults wrong in reset");
    a_reset_regs: assert property (disable iff (1'b0) !i_rst_b |=>
        s.pe == `PPC_PULLUP_RST && s.se == `PPC_SLEW_RST && s.ds == `PPC_DRIVE_RST)
        else $error("pad control reset values wrong");
    a_analog_both: assert property ((i_ana_a_en[1] && i_ana_b_en[1]) |=>
        o_ana_a_conn[1] && o_ana_b_conn[1])
        else $error("shared analog pin not given to both");
    a_irq_role: assert property ((i_irq_en && !s.rst_en && s.rst_d && !i_wr) |=>
        o_p5_role == PPC_P5_IRQ)
        else $error("irq role not taken");
    a_pin5_no_drive: assert property (!o_pad_oe[5])
        else $error("input only pin driven");
    a_tmr_over_port: assert property ((i_tpm1_oe[0] && !i_ana_a_en[0] && !i_ana_b_en[0]) |=>
        o_pad_oe[0] && o_pad_do[0] == $past(i_tpm1_do[0]))
        else $error("timer output lost priority");
    a_dbg_rx_gated: assert property (!o_dbg_role |-> !o_dbg_rx)
        else $error("debug receive while role off");
    a_rst_pullup: assert property ((o_p5_role == PPC_P5_RESET) |-> o_pad_pu[5])
        else $error("reset pin without pullup");

    c_enter_bg: cover property ($rose(o_mode_bg));
    c_dbg_released: cover property ($fell(o_dbg_role) ##[1:4] o_pad_oe[4]);
    c_reset_role: cover property ($rose(o_p5_role == PPC_P5_RESET));
    c_kbi_pulldown: cover property (o_pad_pd[2]);
endmodule

// ---- verif/ppc_board.sv ----
`timescale 1ns/1ns
module ppc_board (
    input wire logic i_clk_sys,
    input wire logic [5:0] i_oe,
    input wire logic [5:0] i_do,
    input wire logic [5:0] i_pu,
    input wire logic [5:0] i_pd,
    input wire logic [5:0] i_ext_en,
    input wire logic [5:0] i_ext_val,
    output logic [5:0] o_level
);
    // an undriven, unpulled pin toggles so a lucky settled value cannot pass
    logic [5:0] flt = 6'h00;
    always @(posedge i_clk_sys) begin
        flt <= ~flt;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (i_oe[i])
                o_level[i] = i_do[i];
            else if (i_ext_en[i])
                o_level[i] = i_ext_val[i];
            else if (i_pu[i])
                o_level[i] = 1'b1;
            else if (i_pd[i])
                o_level[i] = 1'b0;
            else
                o_level[i] = flt[i];
        end
    end
endmodule

// ---- verif/test_ppc_pin_ctrl.sv ----
`timescale 1ns/1ns
`include "ppc_regs.svh"
module test_ppc_pin_ctrl;
    import ppc_pkg::*;
    logic i_clk_sys, i_rst_b, i_por, i_force_rst, i_wr, i_rd, i_tpm2_oe, i_tpm2_do, i_tpm2_ic_en;
    logic i_irq_en, i_irq_rise, i_bdc_oe, i_bdc_do, o_dbg_rx, o_dbg_role, o_mode_bg, o_irq_in, o_rst_pin_b;
    logic [3:0] i_addr, i_kbi_en, i_kbi_rise, i_ana_a_en, i_ana_b_en, o_ana_a_conn, o_ana_b_conn;
    logic [7:0] i_wdata, o_rdata;
    logic [5:0] i_pad_di, i_port_dir, i_port_do, ext_en, ext_val, o_pad_oe, o_pad_do;
    logic [5:0] o_pad_pu, o_pad_pd, o_pad_slew, o_pad_hd, o_pin_in;
    logic [1:0] i_tpm1_oe, i_tpm1_do, i_tclk_en;
    ppc_p5_role_t o_p5_role;
    int fails = 0;
    int check_count = 0;
    ppc_pin_ctrl uut (.*);
    ppc_board board (.i_clk_sys(i_clk_sys), .i_oe(o_pad_oe), .i_do(o_pad_do), .i_pu(o_pad_pu),
        .i_pd(o_pad_pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pad_di));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask
    // the pod keeps mode select low past the release edge, as a debugger would
    task automatic rst(input logic por, input logic frc, input logic hold);
        @(posedge i_clk_sys);
        i_rst_b <= 1'b0;
        i_por <= por;
        i_force_rst <= frc;
        ext_en[4] <= hold;
        repeat (4) @(posedge i_clk_sys);
        #1 chk(o_pad_oe, 8'h00);
        @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        i_por <= 1'b0;
        i_force_rst <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        ext_en[4] <= 1'b0;
        #1;
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #100000;
        fails++;
        tally_and_finish;
    end
    initial begin
        {i_rst_b, i_por, i_force_rst, i_wr, i_rd, i_tpm2_oe, i_tpm2_do, i_tpm2_ic_en} = 8'h40;
        {i_irq_en, i_irq_rise, i_bdc_oe, i_bdc_do} = 4'h0;
        {i_addr, i_kbi_en, i_kbi_rise, i_ana_a_en, i_ana_b_en} = 20'h00000;
        {i_wdata, i_port_dir, i_port_do, ext_en, ext_val} = 32'h00000000;
        {i_tpm1_oe, i_tpm1_do, i_tclk_en} = 6'h00;
        repeat (2) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        rst(1'b1, 1'b0, 1'b1);
        chk(o_mode_bg, 8'h01);
        chk(o_p5_role, PPC_P5_RESET);
        rd(`PPC_STATUS_OFS, 8'h07);
        rst(1'b1, 1'b0, 1'b0);
        chk(o_mode_bg, 8'h00);
        chk(o_dbg_role, 8'h01);
        chk(o_p5_role, PPC_P5_GPIO);
        chk(o_pad_pu, 8'h10);
        chk(o_pad_pd | o_pad_slew | o_pad_hd, 8'h00);
        rd(`PPC_SLEW_OFS, 8'h10);
        rd(`PPC_DRIVE_OFS, 8'h00);
        rd(`PPC_PULLUP_OFS, 8'h00);
        rd(`PPC_STATUS_OFS, 8'h01);
        rd(4'hf, 8'h00);
        chk(o_dbg_rx, 8'h01);
        // drive every pin from outside so the sampled levels are known
        ext_en <= 6'h3f;
        ext_val <= 6'h2f;
        settle;
        settle;
        chk(o_dbg_rx, 8'h00);
        chk(o_pin_in, 8'h2f);
        ext_en <= 6'h00;
        wr(`PPC_PULLUP_OFS, 8'h3f);
        @(posedge i_clk_sys);
        #1 chk(o_pad_pu, 8'h3f);
        chk(o_dbg_rx, 8'h01);
        i_port_dir <= 6'h01;
        i_ana_a_en <= 4'h2;
        i_ana_b_en <= 4'h2;
        i_kbi_en <= 4'h4;
        i_kbi_rise <= 4'h4;
        i_irq_en <= 1'b1;
        i_irq_rise <= 1'b1;
        settle;
        chk(o_pad_pu, 8'h18);
        chk(o_pad_pd, 8'h24);
        chk({o_ana_a_conn, o_ana_b_conn}, 8'h22);
        chk(o_p5_role, PPC_P5_IRQ);
        i_tpm1_oe <= 2'h3;
        i_tpm1_do <= 2'h3;
        wr(`PPC_SLEW_OFS, 8'h3f);
        wr(`PPC_DRIVE_OFS, 8'h3f);
        settle;
        chk(o_pad_oe, 8'h01);
        chk(o_pad_do[0], 8'h01);
        chk(o_pad_slew, 8'h01);
        chk(o_pad_hd, 8'h01);
        wr(`PPC_DRIVE_OFS, 8'h00);
        @(posedge i_clk_sys);
        #1 chk(o_pad_hd, 8'h00);
        i_tpm2_oe <= 1'b1;
        i_bdc_oe <= 1'b1;
        i_bdc_do <= 1'b1;
        settle;
        chk({o_pad_oe[4], o_pad_do[4], o_pad_pu[4]}, 8'h07);
        i_bdc_oe <= 1'b0;
        settle;
        chk(o_pad_oe[4], 8'h00);
        wr(`PPC_OPTIONS_OFS, 8'h00);
        settle;
        chk(o_dbg_role, 8'h00);
        chk({o_pad_oe[4], o_pad_do[4], o_pad_pu[4]}, 8'h04);
        wr(`PPC_OPTIONS_OFS, 8'h02);
        @(posedge i_clk_sys);
        #1 chk(o_p5_role, PPC_P5_RESET);
        i_bdc_oe <= 1'b1;
        rst(1'b0, 1'b1, 1'b0);
        chk(o_dbg_role, 8'h01);
        chk(o_mode_bg, 8'h00);
        chk(o_p5_role, PPC_P5_RESET);
        rd(`PPC_STATUS_OFS, 8'h05);
        ext_val <= 6'h00;
        ext_en <= 6'h20;
        settle;
        settle;
        chk(o_rst_pin_b, 8'h00);
        chk(o_irq_in, 8'h00);
        tally_and_finish;
    end
endmodule
